// File: core/dram_ctl.sv
// Purpose: Drives chip enable, select, address and write strobe of a 4096x1 dynamic memory
// Assumes: User holds REQ with its fields until ACK; RMW writes back WDATA after the read
// Notes: Refresh has priority over user requests; chip enable high time never nears its maximum
`default_nettype none
`include "dram_ctl_cfg.svh"
module dram_ctl
   import dram_ctl_pkg::*;
(
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic REQ,
   input wire logic [1:0] OP,
   input wire logic [`ADDR_BITS-1:0] ADDR,
   input wire logic WDATA,
   output logic ACK,
   output logic RDATA,
   output logic BUSY,
   output logic CE,
   output logic CS_N,
   output logic [`ADDR_BITS-1:0] A,
   output logic WE_N,
   output logic DIN,
   input wire logic DOUT_N
);
   state_e state_reg;
   req_s cur_reg;
   logic [`CNT_BITS-1:0] tim_reg;
   logic [`CNT_BITS-1:0] ref_tim_reg;
   logic ref_pend_reg;
   logic [`ROW_BITS-1:0] row_reg;
   logic dout_s1_reg;
   logic dout_s2_reg;
   logic [`CNT_BITS-1:0] ceh_need;
   logic is_rmw;
   logic is_wr;
   logic is_rd;
   logic take_ref;
   logic take_usr;
   logic ce_end;
   logic low_end;
   logic we_start;
   logic rd_take;

   // Data pin from the memory passes two flops
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         dout_s1_reg <= 1'b0;
         dout_s2_reg <= 1'b0;
      end else begin
         dout_s1_reg <= DOUT_N;
         dout_s2_reg <= dout_s1_reg;
      end
   end

   // Cycle type of the access in flight
   assign is_rmw = (cur_reg.op == OP_RMW);
   assign is_wr = (cur_reg.op == OP_WRITE) || is_rmw;
   assign is_rd = (cur_reg.op == OP_READ) || is_rmw;
   // Enable high time by cycle type; plain reads stay high until data is through the sync
   assign ceh_need = is_rmw ? `CNT_BITS'(`N_CEH_RMW) :
      (cur_reg.op == OP_READ) ? `CNT_BITS'(`N_CEH_RD) : `CNT_BITS'(`N_CEH_RW);

   // Start and end conditions of each phase; a pending refresh goes first
   assign take_ref = (state_reg == ST_IDLE) && ref_pend_reg;
   assign take_usr = (state_reg == ST_IDLE) && !ref_pend_reg && REQ && (OP != 2'(OP_REFRESH));
   assign ce_end = (state_reg == ST_HIGH) && (tim_reg == ceh_need - `CNT_BITS'(1));
   assign low_end = (state_reg == ST_LOW) && (tim_reg == `CNT_BITS'(`N_CEL - 1));
   // Strobe falls a full write setup before enable falls
   assign we_start = (state_reg == ST_HIGH) && is_wr && (tim_reg == ceh_need - `CNT_BITS'(`N_WR_DELAY + 1));
   // Data sampled after access time and sync delay, taken while enable is still high
   assign rd_take = (state_reg == ST_HIGH) && is_rd && (tim_reg == `CNT_BITS'(`N_SAMPLE));

   // Refresh interval timer; request set wins over the clear on service
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         ref_tim_reg <= '0;
         ref_pend_reg <= 1'b0;
      end else begin
         if (ref_tim_reg == `CNT_BITS'(`N_REF - 1)) begin
            ref_tim_reg <= '0;
            ref_pend_reg <= 1'b1;
         end else begin
            ref_tim_reg <= ref_tim_reg + `CNT_BITS'(1);
            if (state_reg == ST_IDLE && ref_pend_reg) begin
               ref_pend_reg <= 1'b0;
            end
         end
      end
   end

   // Row refresh counter steps after each refresh access
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         row_reg <= '0;
      end else if (state_reg == ST_DONE && cur_reg.op == OP_REFRESH) begin
         row_reg <= row_reg + `ROW_BITS'(1);
      end
   end

   // Phase sequencer
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (take_ref || take_usr) begin
                  state_reg <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               if (ce_end) begin
                  state_reg <= ST_LOW;
               end
            end
            ST_LOW: begin
               if (low_end) begin
                  state_reg <= ST_DONE;
               end
            end
            ST_DONE: begin
               state_reg <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Phase timer, cleared in idle and when enable falls
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         tim_reg <= '0;
      end else if (state_reg == ST_IDLE || ce_end) begin
         tim_reg <= '0;
      end else if (state_reg == ST_HIGH || state_reg == ST_LOW) begin
         tim_reg <= tim_reg + `CNT_BITS'(1);
      end
   end

   // Access in flight, captured at the take
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         cur_reg <= '0;
      end else if (take_ref) begin
         cur_reg.op <= OP_REFRESH;
         cur_reg.addr <= {{(`ADDR_BITS-`ROW_BITS){1'b0}}, row_reg};
         cur_reg.wdata <= 1'b0;
      end else if (take_usr) begin
         cur_reg.op <= op_e'(OP);
         cur_reg.addr <= ADDR;
         cur_reg.wdata <= WDATA;
      end
   end

   // Chip enable pulse
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         CE <= 1'b0;
      end else if (take_ref || take_usr) begin
         CE <= 1'b1;
      end else if (ce_end) begin
         CE <= 1'b0;
      end
   end

   // Select: high for refresh reads, low for user cycles, released after the low phase
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         CS_N <= 1'b1;
      end else if (take_ref) begin
         CS_N <= 1'b1;
      end else if (take_usr) begin
         CS_N <= 1'b0;
      end else if (low_end) begin
         CS_N <= 1'b1;
      end
   end

   // Address: the row counter for refresh, the user word otherwise
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         A <= '0;
      end else if (take_ref) begin
         A <= {{(`ADDR_BITS-`ROW_BITS){1'b0}}, row_reg};
      end else if (take_usr) begin
         A <= ADDR;
      end
   end

   // Write data to the memory, set up at the take
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         DIN <= 1'b0;
      end else if (take_usr) begin
         DIN <= WDATA;
      end
   end

   // Write strobe, back high when enable falls
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         WE_N <= 1'b1;
      end else if (ce_end) begin
         WE_N <= 1'b1;
      end else if (we_start) begin
         WE_N <= 1'b0;
      end
   end

   // Read data, held until the next read; refresh reads never touch it
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         RDATA <= 1'b0;
      end else if (rd_take) begin
         RDATA <= ~dout_s2_reg;
      end
   end

   // One-cycle acknowledge once a user access has finished its low phase
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         ACK <= 1'b0;
      end else begin
         ACK <= (state_reg == ST_DONE) && (cur_reg.op != OP_REFRESH);
      end
   end

   // Busy from the take to the end of the access, refresh included
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         BUSY <= 1'b0;
      end else if (take_ref || take_usr) begin
         BUSY <= 1'b1;
      end else if (state_reg == ST_DONE) begin
         BUSY <= 1'b0;
      end
   end
endmodule : dram_ctl
`default_nettype wire

// File: core/dram_ctl_cfg.svh
// Purpose: Timing constants and bit positions for the dynamic memory controller
// Assumes: MCLK at 25 MHz, 40 ns period
// Notes: Counts are least times in clocks, rounded up; reads add the pin sync delay
// Behaviour
// - All 64 rows, from six low address bits, accessed within every 2 ms.
// - Select held low during a write or read-modify-write used for refresh.
// - Select may be high or low during a read used for refresh.
// - Chip enable low phase lasts at least 130 ns on every cycle type.
// - Read/write: enable high 180 to 4000 ns, cycle start at least 320 ns apart.
// - Read-modify-write: enable high 300 to 4000 ns, cycles 470 ns apart.
`ifndef DRAM_CTL_CFG_SVH
`define DRAM_CTL_CFG_SVH
`define CLK_PERIOD_NS 40
`define CYC_NS(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_CEL_NS 130
`define T_CEH_RW_NS 180
`define T_CEH_RMW_NS 300
`define T_CEH_MAX_NS 4000
`define T_CYC_RW_NS 320
`define T_CYC_RMW_NS 470
`define T_ACC_CE_NS 130
`define T_WR_DELAY_NS 150
`define T_WR_PULSE_NS 50
`define T_REF_US 31
`define N_CEL `CYC_NS(`T_CEL_NS)
`define N_CEH_RW `CYC_NS(`T_CEH_RW_NS)
`define N_CEH_RMW `CYC_NS(`T_CEH_RMW_NS)
`define N_ACC `CYC_NS(`T_ACC_CE_NS)
`define N_SYNC 2
`define N_SAMPLE (`N_ACC + `N_SYNC)
`define N_CEH_RD (`N_SAMPLE + 1)
`define N_WR_DELAY `CYC_NS(`T_WR_DELAY_NS)
`define N_WR_PULSE `CYC_NS(`T_WR_PULSE_NS)
`define N_REF ((`T_REF_US * 1000) / `CLK_PERIOD_NS)
`define ROW_BITS 6
`define ADDR_BITS 12
`define CNT_BITS 10
`endif

// File: core/dram_ctl_pkg.sv
// Purpose: Types shared by the dynamic memory controller
// Assumes: Constants come from the cfg header
// Notes: One-hot state codes written out
`default_nettype none
`include "dram_ctl_cfg.svh"
package dram_ctl_pkg;
   typedef enum logic [1:0] {
      OP_READ = 2'h0,
      OP_WRITE = 2'h1,
      OP_RMW = 2'h2,
      OP_REFRESH = 2'h3
   } op_e;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_HIGH = 5'h02,
      ST_WRITE = 5'h04,
      ST_LOW = 5'h08,
      ST_DONE = 5'h10
   } state_e;
   typedef struct packed {
      op_e op;
      logic [`ADDR_BITS-1:0] addr;
      logic wdata;
   } req_s;
endpackage : dram_ctl_pkg
`default_nettype wire

// File: tb/dram_ctl_assertions.sv
// Purpose: Pin timing checks for the controller
// Assumes: 40 ns clock
// Notes: Refresh spacing kept in a counter
`default_nettype none
module dram_ctl_assertions (
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic REQ,
   input wire logic [1:0] OP,
   input wire logic ACK,
   input wire logic BUSY,
   input wire logic CE,
   input wire logic CS_N,
   input wire logic WE_N
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge MCLK); endclocking
   default disable iff (RESET);
   logic [9:0] gap_reg;
   // Cycles since the last refresh access
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) gap_reg <= 10'h000;
      else if (CE && CS_N) gap_reg <= 10'h000;
      else gap_reg <= gap_reg + 10'h001;
   end
   sequence rise_s; $rose(CE); endsequence
   sequence rmw_s; $rose(CE) && !CS_N && $past(REQ) && $past(OP) == 2'h2; endsequence
   chk_cel_min: assert property ($fell(CE) |-> !CE[*4]) else $error("enable low too short");
   chk_ceh_rw: assert property (rise_s |-> CE[*5]) else $error("enable high too short");
   chk_ceh_rmw: assert property (rmw_s |-> CE[*8]) else $error("rmw enable high too short");
   chk_ceh_max: assert property (rise_s |-> ##[1:100] !CE) else $error("enable high too long");
   chk_cyc_rw: assert property (rise_s |=> (!$rose(CE))[*7]) else $error("cycle too short");
   chk_cyc_rmw: assert property (rmw_s |=> (!$rose(CE))[*8] ##1 (!$rose(CE))[*3]) else $error("rmw cycle short");
   chk_write_sel: assert property (!WE_N |-> !CS_N) else $error("write while deselected");
   chk_ref_gap: assert property (gap_reg <= 10'h320) else $error("refresh late");
   chk_req_ack: assert property (REQ && OP != 2'h3 && !BUSY && !ACK |-> ##[1:30] ACK) else $error("no ack");
endmodule : dram_ctl_assertions
`default_nettype wire

// File: tb/dram_model.sv
// Purpose: Behavioural 4096x1 dynamic memory
// Assumes: Driven only by the controller pins
// Notes: Deselected output toggles, like a floating line
`default_nettype none
module dram_model (
   input wire logic CE,
   input wire logic CS_N,
   input wire logic [11:0] A,
   input wire logic WE_N,
   input wire logic DIN,
   output logic DOUT_N
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam time RETAIN_NS = 64'h1E8480; // 2 ms row retention
   logic cells [4096];
   time stamp [64] = '{default: 0};
   logic stale;
   initial DOUT_N = 1'b0;
   // Row access on enable rise refreshes the row; a row left too long loses its cells
   always @(posedge CE) begin
      stale = ($time - stamp[A[5:0]]) > RETAIN_NS;
      if (stale) begin
         for (int c = 0; c < 64; c++) cells[{6'(c), A[5:0]}] = 1'bx;
      end
      stamp[A[5:0]] = $time;
      #100 DOUT_N = CS_N ? ~DOUT_N : ~cells[A];
   end
   // Write on strobe fall while selected
   always @(negedge WE_N) begin
      if (!CS_N) cells[A] = DIN;
   end
endmodule : dram_model
`default_nettype wire

// File: tb/testbench.sv
// Purpose: Self-checking bench for the memory controller
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Long idle lets refresh run
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic MCLK = 1'b0, RESET = 1'b1, REQ = 1'b0, WDATA = 1'b0;
   logic [1:0] OP = 2'h0;
   logic [11:0] ADDR = 12'h000;
   wire logic ACK, RDATA, BUSY, CE, CS_N, WE_N, DIN, DOUT_N;
   wire logic [11:0] A;
   int fails = 0, comparisons = 0;
   dram_ctl u_dut (.MCLK(MCLK), .RESET(RESET), .REQ(REQ), .OP(OP), .ADDR(ADDR), .WDATA(WDATA),
      .ACK(ACK), .RDATA(RDATA), .BUSY(BUSY), .CE(CE), .CS_N(CS_N), .A(A), .WE_N(WE_N),
      .DIN(DIN), .DOUT_N(DOUT_N));
   dram_model u_mem (.CE(CE), .CS_N(CS_N), .A(A), .WE_N(WE_N), .DIN(DIN), .DOUT_N(DOUT_N));
   // Clock
   initial forever #20 MCLK = ~MCLK;
   task automatic check(input string name, input logic seen, input logic exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %b seen %b", name, exp, seen);
      end
   endtask : check
   task automatic conclude;
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   // One user access, held until acknowledged
   task automatic access(input logic [1:0] op, input logic [11:0] ad, input logic wd, output logic rd);
      int n = 0;
      {OP, ADDR, WDATA, REQ} = {op, ad, wd, 1'b1};
      while (ACK !== 1'b1 && n < 40) begin
         @(posedge MCLK);
         #1 n++;
      end
      REQ = 1'b0;
      rd = RDATA;
      check("ack", ACK, op != 2'h3);
      if (n == 40 && op != 2'h3) conclude();
      if (op != 2'h3) check("busy", BUSY, 1'b0);
      @(posedge MCLK);
      #1 check("ack pulse", ACK, 1'b0);
   endtask : access
   // Main sequence
   initial begin
      logic r;
      repeat (6) @(posedge MCLK);
      #1 RESET = 1'b0;
      access(2'h1, 12'hABC, 1'b1, r);
      access(2'h1, 12'h03F, 1'b0, r);
      access(2'h0, 12'hABC, 1'b0, r);
      check("read", r, 1'b1);
      access(2'h2, 12'h03F, 1'b1, r);
      check("rmw old", r, 1'b0);
      access(2'h3, 12'h03F, 1'b0, r);
      repeat (52000) @(posedge MCLK);
      #1 check("hold", RDATA, 1'b0);
      access(2'h0, 12'h03F, 1'b0, r);
      check("rmw new", r, 1'b1);
      access(2'h0, 12'hABC, 1'b0, r);
      check("kept", r, 1'b1);
      conclude();
   end
endmodule : testbench
bind dram_ctl dram_ctl_assertions u_chk (.MCLK(MCLK), .RESET(RESET), .REQ(REQ), .OP(OP),
   .ACK(ACK), .BUSY(BUSY), .CE(CE), .CS_N(CS_N), .WE_N(WE_N));
`default_nettype wire
